// >>> design/timer_cc_regs.vh
`ifndef TIMER_CC_REGS_VH
`define TIMER_CC_REGS_VH
// byte addresses of the register map
`define OFS_TRIG_SEL 8'h00
`define OFS_INTV_STAT 8'h04
`define OFS_CH0_STAT 8'h08
`define OFS_CH1_STAT 8'h0C
`define OFS_IRQ_EN 8'h10
`define OFS_IRQ_CLR 8'h14
`define OFS_INTV_EN 8'h18
`define OFS_IRQ_STAT 8'h1C
`define OFS_FUNC_BASE 8'h20
// function select registers: 5, at 0x20..0x30
`define FUNC_REGS 5
// field positions
`define TRIG_A_BIT 0
`define TRIG_D_BIT 2
`define TRIG_MASK 8'h05
`define INTV_MASK 8'h0F
`define CH0_MASK 8'h1F
`define CH1_MASK 8'h7F
`define CH0_OVF_BIT 4
`define CH1_OVF_BIT 6
`define INTV_LSB 10
// interrupt map: [3:0] interval, [8:4] ch0, [15:9] ch1
`define IRQ_W 16
// reset value
`define RST_BYTE 8'h00
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> design/func_sel_mem.v
`timescale 1ns/1ns
// =====================================================
// function select storage, registered read port
module func_sel_mem (
   input wire aclk,
   input wire aresetn,
   input wire clr,
   input wire ce,
   input wire we,
   input wire [2:0] waddr,
   input wire [7:0] wdata,
   input wire [2:0] raddr,
   output reg [7:0] rdata,
   output wire [39:0] flat
);
   reg [7:0] mem_r [0:4];
   integer i;
   // flattened copy feeds the compare logic
   assign flat = {mem_r[4], mem_r[3], mem_r[2], mem_r[1], mem_r[0]};
   always @(posedge aclk) begin
      if (!aresetn || clr) begin
         for (i = 0; i < 5; i = i + 1)
            mem_r[i] <= 8'h00;
         rdata <= 8'h00;
      end else if (ce) begin
         if (we && waddr < 3'd5)
            mem_r[waddr] <= wdata;
         rdata <= (raddr < 3'd5) ? mem_r[raddr] : 8'h00;
      end
   end
endmodule // func_sel_mem

// >>> design/timer_cc_status.v
`timescale 1ns/1ns
`include "timer_cc_regs.vh"
// Functional notes
// [R1] clear-enable set: match clears the counter
// [R2] clearing only in output compare mode
// [R3] top bit 0: compare output actions
// [R4] top bit 1: capture edge selection
// [R5] trigger bit 2 picks pin D or match
// [R6] trigger bit 0 picks pin A or match
// [R7] reserved bits read zero, write zero
// [R8] trigger select zeroed on reset, standby
// [R9] status registers zeroed on reset, standby
// [R10] enabled set flag raises interrupt
// [R11] read set flag, then write 0 clears
// [R12] interval flags from enable and counter bits
// [R13] interval and channel 0 status layout
// [R14] channel 0 flag on 32-bit wrap
// [R15] channel 0 capture flags on capture
// [R16] channel 1 status layout
// [R17] channel 1 flag on 16-bit wrap
// [R18] channel 1 flags on capture or match
// [R19] hardware set beats software clear
module timer_cc_status (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire standby,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // channel 0 side
   input wire [31:0] ch0_counter,
   input wire capture_pin_a,
   input wire capture_pin_d,
   input wire [3:0] ch0_capture_evt,
   // channel 1 side
   input wire [15:0] ch1_counter,
   input wire [5:0] ch1_capture_evt,
   input wire [5:0] ch1_match_evt,
   input wire [5:0] ch1_is_capture,
   // channels 3 to 5 general registers: a/b/c/d of 3, 4, a/b of 5
   input wire [9:0] gr_match,
   input wire [9:0] gr_pin,
   output reg [9:0] gr_out,
   output reg [9:0] gr_capture,
   output reg [2:0] counter_clear,
   output wire [3:0] ch0_capture_trig,
   output wire irq
);
   // =====================================================
   // state
   reg [7:0] trig_sel_r;
   reg [3:0] intv_stat_r;
   reg [4:0] ch0_stat_r;
   reg [6:0] ch1_stat_r;
   reg [`IRQ_W-1:0] irq_en_r;
   reg [3:0] intv_en_r;
   reg [`IRQ_W-1:0] armed_r;
   reg [3:0] intv_prev_r;
   reg [31:0] ch0_prev_r;
   reg [15:0] ch1_prev_r;
   reg [9:0] pin_prev_r;
   reg pin_a_prev_r;
   reg pin_d_prev_r;
   reg [7:0] aw_addr_r;
   reg aw_full_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg w_full_r;
   reg [7:0] ar_addr_r;
   reg rd_pend_r;
   wire [39:0] func_flat;
   wire [7:0] func_rdata;
   wire clr_all;
   assign clr_all = standby; // R8 R9

   // =====================================================
   // helpers
   // edge detector per capture mode
   function edge_hit;
      input [1:0] mode;
      input prev;
      input cur;
      begin
         case (mode)
            2'b01: edge_hit = !prev && cur;
            2'b10: edge_hit = prev && !cur;
            2'b11: edge_hit = prev ^ cur;
            default: edge_hit = 1'b0;
         endcase
      end
   endfunction
   // address in function window -> index
   function [2:0] func_idx;
      input [7:0] a;
      reg [7:0] d;
      begin
         d = a - `OFS_FUNC_BASE;
         func_idx = (a >= `OFS_FUNC_BASE && d[1:0] == 2'b00 && d[7:5] == 3'b000 &&
            d[4:2] < 3'd5) ? d[4:2] : 3'd7;
      end
   endfunction

   // =====================================================
   // axi write channel
   wire wr_go;
   wire [7:0] wbyte;
   assign s_axi_awready = !aw_full_r && !s_axi_bvalid && ce; // nothing taken while frozen
   assign s_axi_wready = !w_full_r && !s_axi_bvalid && ce;
   assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid && ce;
   assign wbyte = w_data_r[7:0];
   wire wr_lane0;
   assign wr_lane0 = wr_go && w_strb_r[0];
   wire [2:0] widx;
   assign widx = func_idx(aw_addr_r);
   wire wr_ok;
   assign wr_ok = (aw_addr_r == `OFS_TRIG_SEL) || (aw_addr_r == `OFS_INTV_STAT) ||
      (aw_addr_r == `OFS_CH0_STAT) || (aw_addr_r == `OFS_CH1_STAT) ||
      (aw_addr_r == `OFS_IRQ_EN) || (aw_addr_r == `OFS_IRQ_CLR) ||
      (aw_addr_r == `OFS_INTV_EN) || (widx != 3'd7);

   // capture address and data in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // =====================================================
   // function select storage for channels 3 to 5
   wire [2:0] ridx;
   assign ridx = func_idx(ar_addr_r);
   // memory looks up the bus address on accept, so its data stand when the read fires
   func_sel_mem u_func (
      .aclk(aclk),
      .aresetn(aresetn),
      .clr(clr_all),
      .ce(ce),
      .we(wr_lane0 && widx != 3'd7),
      .waddr(widx),
      .wdata(wbyte),
      .raddr((s_axi_arvalid && s_axi_arready) ? func_idx(s_axi_araddr) : ridx),
      .rdata(func_rdata),
      .flat(func_flat)
   );

   // =====================================================
   // compare output, capture and clearing per general register
   // each 8-bit function register carries two 4-bit slots
   reg [9:0] out_nxt;
   reg [9:0] cap_nxt;
   reg [2:0] clr_nxt;
   reg [3:0] slot;
   integer g;
   always @* begin
      out_nxt = gr_out;
      cap_nxt = 10'h000;
      clr_nxt = 3'b000;
      slot = 4'h0;
      for (g = 0; g < 10; g = g + 1) begin
         slot = func_flat[g*4 +: 4];
         if (!slot[2]) begin // R3
            if (gr_match[g]) begin
               case (slot[1:0])
                  2'b01: out_nxt[g] = 1'b0;
                  2'b10: out_nxt[g] = 1'b1;
                  2'b11: out_nxt[g] = !gr_out[g];
                  default: out_nxt[g] = 1'b0;
               endcase
               // clearing is gated off in capture mode
               if (slot[3])
                  clr_nxt[(g < 4) ? 0 : (g < 8) ? 1 : 2] = 1'b1; // R1 R2
            end else if (slot[1:0] == 2'b00) begin
               out_nxt[g] = 1'b0;
            end
         end else begin
            cap_nxt[g] = edge_hit(slot[1:0], pin_prev_r[g], gr_pin[g]); // R4
         end
      end
   end

   always @(posedge aclk) begin
      if (!aresetn || clr_all) begin
         gr_out <= 10'h000;
         gr_capture <= 10'h000;
         counter_clear <= 3'b000;
         pin_prev_r <= 10'h000;
      end else if (ce) begin
         gr_out <= out_nxt;
         gr_capture <= cap_nxt;
         counter_clear <= clr_nxt;
         pin_prev_r <= gr_pin;
      end
   end

   // =====================================================
   // channel 0 capture trigger routing
   // match source is channel 1 register a, flag bit 0 of its events
   wire ch1_match_trigger;
   assign ch1_match_trigger = ch1_match_evt[0] && !ch1_is_capture[0];
   assign ch0_capture_trig[0] = trig_sel_r[`TRIG_A_BIT] ? ch1_match_trigger :
      (capture_pin_a && !pin_a_prev_r); // R6
   assign ch0_capture_trig[1] = 1'b0;
   assign ch0_capture_trig[2] = 1'b0;
   assign ch0_capture_trig[3] = trig_sel_r[`TRIG_D_BIT] ? ch1_match_trigger :
      (capture_pin_d && !pin_d_prev_r); // R5

   // =====================================================
   // status flags: events, read-arm, clear by 0 write
   wire [3:0] intv_lvl = intv_en_r & ch0_counter[`INTV_LSB +: 4];
   wire [3:0] intv_set = intv_lvl & ~intv_prev_r; // R12
   wire ch0_overflow_flag = (ch0_prev_r == 32'hFFFF_FFFF) && (ch0_counter == 32'h0000_0000); // R14
   wire ch1_overflow_flag = (ch1_prev_r == 16'hFFFF) && (ch1_counter == 16'h0000); // R17
   wire [4:0] ch0_set = {ch0_overflow_flag, ch0_capture_evt}; // R13 R15
   wire [6:0] ch1_set = {ch1_overflow_flag, ch1_capture_evt | (ch1_match_evt & ~ch1_is_capture)}; // R16 R18
   wire [`IRQ_W-1:0] stat_all = {ch1_stat_r, ch0_stat_r, intv_stat_r};
   // a zero write clears only bits armed by an earlier read while set
   wire [`IRQ_W-1:0] clr_intv = (wr_lane0 && aw_addr_r == `OFS_INTV_STAT) ?
      {12'h000, ~wbyte[3:0]} : 16'h0000;
   wire [`IRQ_W-1:0] clr_ch0 = (wr_lane0 && aw_addr_r == `OFS_CH0_STAT) ?
      {7'h00, ~wbyte[4:0], 4'h0} : 16'h0000;
   wire [`IRQ_W-1:0] clr_ch1 = (wr_lane0 && aw_addr_r == `OFS_CH1_STAT) ?
      {~wbyte[6:0], 9'h000} : 16'h0000;
   // clear register: write 1 clears, no read needed
   wire [`IRQ_W-1:0] clr_irq = (wr_go && aw_addr_r == `OFS_IRQ_CLR) ?
      w_data_r[15:0] : 16'h0000;
   wire [`IRQ_W-1:0] clr_hit = ((clr_intv | clr_ch0 | clr_ch1) & armed_r) | clr_irq; // R11
   wire [`IRQ_W-1:0] stat_nxt = (stat_all & ~clr_hit) | {ch1_set, ch0_set, intv_set}; // R19
   wire rd_fire = rd_pend_r && !s_axi_rvalid && ce;

   always @(posedge aclk) begin
      if (!aresetn || clr_all) begin
         intv_stat_r <= 4'h0; // R9
         ch0_stat_r <= 5'h00;
         ch1_stat_r <= 7'h00;
         armed_r <= 16'h0000;
         trig_sel_r <= `RST_BYTE; // R8
         irq_en_r <= 16'h0000;
         intv_en_r <= 4'h0;
         intv_prev_r <= 4'h0;
         ch0_prev_r <= 32'h0000_0000;
         ch1_prev_r <= 16'h0000;
         pin_a_prev_r <= 1'b0;
         pin_d_prev_r <= 1'b0;
      end else if (ce) begin
         intv_stat_r <= stat_nxt[3:0];
         ch0_stat_r <= stat_nxt[8:4];
         ch1_stat_r <= stat_nxt[15:9];
         intv_prev_r <= intv_lvl;
         ch0_prev_r <= ch0_counter;
         ch1_prev_r <= ch1_counter;
         pin_a_prev_r <= capture_pin_a;
         pin_d_prev_r <= capture_pin_d;
         // arm on read of a set flag, disarm once cleared
         if (rd_fire && ar_addr_r == `OFS_INTV_STAT)
            armed_r[3:0] <= intv_stat_r;
         else if (rd_fire && ar_addr_r == `OFS_CH0_STAT)
            armed_r[8:4] <= ch0_stat_r;
         else if (rd_fire && ar_addr_r == `OFS_CH1_STAT)
            armed_r[15:9] <= ch1_stat_r;
         else
            armed_r <= armed_r & stat_nxt;
         if (wr_lane0 && aw_addr_r == `OFS_TRIG_SEL)
            trig_sel_r <= wbyte & `TRIG_MASK; // R7
         if (wr_go && aw_addr_r == `OFS_IRQ_EN)
            irq_en_r <= w_data_r[15:0];
         if (wr_lane0 && aw_addr_r == `OFS_INTV_EN)
            intv_en_r <= wbyte[3:0];
      end
   end

   // any enabled set flag holds the request
   assign irq = |(stat_all & irq_en_r); // R10

   // =====================================================
   // axi read channel
   assign s_axi_arready = !rd_pend_r && !s_axi_rvalid && ce;
   reg [31:0] rd_mux;
   reg rd_ok;
   // decode the held read address
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_ok = 1'b1;
      if (ar_addr_r == `OFS_TRIG_SEL) begin
         rd_mux[7:0] = trig_sel_r & `TRIG_MASK; // R7
      end else if (ar_addr_r == `OFS_INTV_STAT) begin
         rd_mux[3:0] = intv_stat_r;
      end else if (ar_addr_r == `OFS_CH0_STAT) begin
         rd_mux[4:0] = ch0_stat_r;
      end else if (ar_addr_r == `OFS_CH1_STAT) begin
         rd_mux[6:0] = ch1_stat_r;
      end else if (ar_addr_r == `OFS_IRQ_EN) begin
         rd_mux[15:0] = irq_en_r;
      end else if (ar_addr_r == `OFS_IRQ_CLR) begin
         rd_mux = 32'h0000_0000; // write-only
      end else if (ar_addr_r == `OFS_INTV_EN) begin
         rd_mux[3:0] = intv_en_r;
      end else if (ar_addr_r == `OFS_IRQ_STAT) begin
         rd_mux[15:0] = stat_all;
      end else if (ridx != 3'd7) begin
         rd_mux[7:0] = func_rdata;
      end else begin
         rd_ok = 1'b0;
      end
   end

   // two-stage read: address in, then one cycle for memory output
   always @(posedge aclk) begin
      if (!aresetn) begin
         ar_addr_r <= 8'h00;
         rd_pend_r <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            ar_addr_r <= s_axi_araddr;
            rd_pend_r <= 1'b1;
         end else if (rd_fire) begin
            rd_pend_r <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule // timer_cc_status

// >>> bench/timer_cc_sva.sv
`timescale 1ns/1ns
// ==============================
// port-level checks
module timer_cc_sva (
   input wire aclk,
   input wire aresetn,
   input wire ce,
   input wire standby,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire capture_pin_a,
   input wire capture_pin_d,
   input wire [5:0] ch1_match_evt,
   input wire [9:0] gr_match,
   input wire [9:0] gr_pin,
   input wire [9:0] gr_out,
   input wire [9:0] gr_capture,
   input wire [2:0] counter_clear,
   input wire [3:0] ch0_capture_trig,
   input wire irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // any match per counter group, ch3 in bit 0
   wire [2:0] grp = {|gr_match[9:8], |gr_match[7:4], |gr_match[3:0]};
   // both write halves taken at once; a read taken
   sequence s_wr;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
   endsequence
   sequence s_rd;
      s_axi_arvalid && s_axi_arready && ce;
   endsequence
   AST_WR_RESP: assert property (s_wr |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   AST_RD_RESP: assert property (s_rd |-> ##[1:3] s_axi_rvalid)
      else $error("read answer late");
   AST_CLR_CAUSE: assert property ((counter_clear & ~$past(grp)) == 3'h0)
      else $error("clear without match");
   AST_CAP_EDGE: assert property ((gr_capture & ~($past(gr_pin) ^ $past(gr_pin, 2))) == 10'h0)
      else $error("capture without edge");
   AST_OUT_RISE: assert property ((gr_out & ~$past(gr_out) & ~$past(gr_match)) == 10'h0)
      else $error("output rose without match");
   AST_TRIG_A: assert property (ch0_capture_trig[0] |-> ch1_match_evt[0] || $rose(capture_pin_a))
      else $error("stray trigger a");
   AST_TRIG_D: assert property (ch0_capture_trig[3] |-> ch1_match_evt[0] || $rose(capture_pin_d))
      else $error("stray trigger d");
   AST_STBY_IRQ: assert property (standby |=> !irq)
      else $error("irq kept in standby");
endmodule // timer_cc_sva

bind timer_cc_status timer_cc_sva i_sva (.aclk, .aresetn, .ce, .standby, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rvalid, .capture_pin_a, .capture_pin_d, .ch1_match_evt, .gr_match,
   .gr_pin, .gr_out, .gr_capture, .counter_clear, .ch0_capture_trig, .irq);

// >>> bench/pin_model.sv
`timescale 1ns/1ns
// ==============================
// far side: counters, pins, event pulses
module pin_model (
   input wire aclk,
   output reg [31:0] ch0_counter,
   output reg [15:0] ch1_counter,
   output reg capture_pin_a,
   output reg capture_pin_d,
   output reg [9:0] gr_pin,
   output reg [3:0] ch0_capture_evt,
   output reg [5:0] ch1_capture_evt,
   output reg [5:0] ch1_match_evt,
   output reg [9:0] gr_match
);
   // quiet levels from time zero
   initial begin
      {ch0_counter, ch1_counter, capture_pin_a, capture_pin_d, gr_pin} = 60'h0;
      {ch0_capture_evt, ch1_capture_evt, ch1_match_evt, gr_match} = 26'h0;
   end
   // counters jump only when told, so wraps are exact
   task cnt(input [31:0] c0, input [15:0] c1);
      begin
         @(posedge aclk);
         ch0_counter <= c0;
         ch1_counter <= c1;
      end
   endtask
   // pin levels, {d, a} and general pins
   task pin(input [1:0] ad, input [9:0] gp);
      begin
         @(posedge aclk);
         {capture_pin_d, capture_pin_a} <= ad;
         gr_pin <= gp;
      end
   endtask
   // event levels from the next edge on, until changed
   task ev(input [3:0] e0, input [5:0] c1, input [5:0] m1, input [9:0] gm);
      begin
         @(posedge aclk);
         {ch0_capture_evt, ch1_capture_evt, ch1_match_evt, gr_match} <= {e0, c1, m1, gm};
      end
   endtask
   // events last one cycle, as the counters produce them
   task pulse(input [3:0] e0, input [5:0] c1, input [5:0] m1, input [9:0] gm);
      begin
         ev(e0, c1, m1, gm);
         ev(4'h0, 6'h0, 6'h0, 10'h0);
      end
   endtask
endmodule // pin_model

// >>> bench/tb.sv
`timescale 1ns/1ns
`include "timer_cc_regs.vh"
// ==============================
// register-level bench
module tb;
   // compare codes, first in the low nibble
   localparam [23:0] FC = 24'h02_133A;
   localparam [5:0] FO = 6'h15;
   reg aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, standby = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg [5:0] ch1_is_capture = 6'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   wire capture_pin_a, capture_pin_d;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata, ch0_counter;
   wire [15:0] ch1_counter;
   wire [3:0] ch0_capture_evt, ch0_capture_trig;
   wire [5:0] ch1_capture_evt, ch1_match_evt;
   wire [9:0] gr_match, gr_pin, gr_out, gr_capture;
   wire [2:0] counter_clear;
   integer errors = 0, checks_done = 0, i;
   reg [31:0] rv;
   reg [1:0] resp;
   timer_cc_status i_timer_cc_status (.aclk, .aresetn, .ce, .standby, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ch0_counter, .capture_pin_a,
      .capture_pin_d, .ch0_capture_evt, .ch1_counter, .ch1_capture_evt, .ch1_match_evt,
      .ch1_is_capture, .gr_match, .gr_pin, .gr_out, .gr_capture, .counter_clear,
      .ch0_capture_trig, .irq);
   pin_model i_pin_model (.aclk, .ch0_counter, .ch1_counter, .capture_pin_a, .capture_pin_d,
      .gr_pin, .ch0_capture_evt, .ch1_capture_evt, .ch1_match_evt, .gr_match);
   // 50 ns period
   always #25 aclk = ~aclk;
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // both halves offered together, each dropped once taken
   task wr(input [7:0] a, input [31:0] d);
      reg done;
      begin
         done = 1'b0;
         @(posedge aclk);
         {s_axi_awaddr, s_axi_wdata} <= {a, d};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
               done = 1'b1;
               resp = s_axi_bresp;
               s_axi_bready <= 1'b0;
            end
         end
      end
   endtask
   task rd(input [7:0] a, output [31:0] d);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
         do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         end while (!s_axi_rvalid);
         d = s_axi_rdata;
         resp = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   task rdc(input [7:0] a, input [31:0] e);
      begin
         rd(a, rv);
         chk(rv, e);
      end
   endtask
   // write, let it land, then look at the irq level
   task wi(input [7:0] a, input [31:0] d, input e);
      begin
         wr(a, d);
         @(negedge aclk);
         chk(32'(irq), 32'(e));
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d errors %0d", checks_done, errors);
         if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   // hang guard: the sequence needs well under a tenth of this
   initial begin
      #400000;
      errors = errors + 1;
      wrap_up;
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // whole map zero after reset; unmapped word refused
      for (i = 0; i < 13; i = i + 1)
         rdc(8'(4 * i), 32'h0);
      rd(8'h40, rv);
      chk(32'(resp), 32'(`RESP_SLVERR));
      rd(8'h34, rv);
      chk(32'(resp), 32'(`RESP_SLVERR));
      // reserved select bits stay zero; ch1 match then drives both triggers
      wr(`OFS_TRIG_SEL, 32'hFF);
      rdc(`OFS_TRIG_SEL, 32'h5);
      i_pin_model.ev(4'h0, 6'h0, 6'h1, 10'h0);
      @(negedge aclk);
      chk(32'(ch0_capture_trig), 32'h9);
      // register a in capture mode gives no match trigger
      @(posedge aclk) ch1_is_capture <= 6'h1;
      @(negedge aclk);
      chk(32'(ch0_capture_trig), 32'h0);
      i_pin_model.ev(4'h0, 6'h0, 6'h0, 10'h0);
      wr(`OFS_TRIG_SEL, 32'h0);
      i_pin_model.pin(2'h1, 10'h0);
      @(negedge aclk);
      chk(32'(ch0_capture_trig), 32'h1);
      // only flags read while set are cleared by a zero write
      i_pin_model.pulse(4'hF, 6'h1, 6'h3F, 10'h0);
      rdc(`OFS_CH0_STAT, 32'hF);
      i_pin_model.cnt(32'hFFFF_FFFF, 16'hFFFF);
      i_pin_model.cnt(32'h0, 16'h0);
      wr(`OFS_CH0_STAT, 32'h0);
      rdc(`OFS_CH0_STAT, 32'h10);
      wr(`OFS_CH0_STAT, 32'h1F);
      rdc(`OFS_CH0_STAT, 32'h10);
      wr(`OFS_CH0_STAT, 32'h0);
      rdc(`OFS_CH0_STAT, 32'h0);
      rdc(`OFS_CH1_STAT, 32'h7F);
      // interval flags 0 and 2 only
      wr(`OFS_INTV_EN, 32'h5);
      i_pin_model.cnt(32'h3C00, 16'h0);
      rdc(`OFS_INTV_STAT, 32'h5);
      wi(`OFS_IRQ_EN, 32'h1, 1'b1);
      wi(`OFS_IRQ_EN, 32'h0, 1'b0);
      wi(`OFS_IRQ_EN, 32'h1, 1'b1);
      wi(`OFS_IRQ_CLR, 32'h1, 1'b0);
      // every compare action in turn, clear enabled on the first only
      for (i = 0; i < 6; i = i + 1) begin
         wr(`OFS_FUNC_BASE, 32'(FC[i*4 +: 4]));
         i_pin_model.pulse(4'h0, 6'h0, 6'h0, 10'h1);
         @(negedge aclk);
         chk(32'(gr_out[0]), 32'(FO[i]));
         chk(32'(counter_clear[0]), 32'(i == 0));
      end
      // capture codes with clear enabled: edges only, never a clear
      for (i = 4; i < 8; i = i + 1) begin
         wr(`OFS_FUNC_BASE, 32'(i + 8));
         i_pin_model.pulse(4'h0, 6'h0, 6'h0, 10'h1);
         @(negedge aclk);
         chk(32'(counter_clear[0]), 32'h0);
         i_pin_model.pin(2'h0, 10'h1);
         repeat (2) @(negedge aclk);
         chk(32'(gr_capture[0]), 32'(i % 2));
         i_pin_model.pin(2'h0, 10'h0);
         repeat (2) @(negedge aclk);
         chk(32'(gr_capture[0]), 32'(i > 5));
      end
      rdc(`OFS_FUNC_BASE, 32'hF);
      // channel 5 high slot; a match while ce is low is held off
      wr(8'h30, 32'hA0);
      @(posedge aclk) ce <= 1'b0;
      i_pin_model.pulse(4'h0, 6'h0, 6'h0, 10'h200);
      @(negedge aclk);
      chk(32'(gr_out[9]), 32'h0);
      @(posedge aclk) ce <= 1'b1;
      i_pin_model.pulse(4'h0, 6'h0, 6'h0, 10'h200);
      @(negedge aclk);
      chk(32'(gr_out[9]), 32'h1);
      chk(32'(counter_clear), 32'h4);
      // one cycle of standby wipes selection, status and functions
      wr(`OFS_TRIG_SEL, 32'h5);
      @(posedge aclk) standby <= 1'b1;
      @(posedge aclk) standby <= 1'b0;
      rdc(`OFS_TRIG_SEL, 32'h0);
      rdc(`OFS_CH1_STAT, 32'h0);
      rdc(`OFS_FUNC_BASE, 32'h0);
      wrap_up;
   end
endmodule // tb
